// file: hdl/psc_bank_arb.sv
// three bank priority core for four pci requesters
// assumes advance pulses for one clock when a winner is granted
`timescale 1ns/1ns
`default_nettype none
module psc_bank_arb (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// link to control
	psc_arb_if.core ab
);
	import psc_pkg::*;
	logic [2:0] tog;
	logic [2:0] next_tog;
	logic [2:0] b;
	logic [1:0] ord [4];

	// effective bank bits: rotate state wins over fixed select
	assign b = (ab.rot & tog) | (~ab.rot & ab.sel);

	// build order, highest first, then pick first requester
	always_comb begin
		ord[0] = 2'(b[0] ? PSC_M0 : PSC_BRIDGE);
		ord[1] = 2'(b[0] ? PSC_BRIDGE : PSC_M0);
		ord[2] = 2'(b[1] ? PSC_M1 : PSC_CPU);
		ord[3] = 2'(b[1] ? PSC_CPU : PSC_M1);
		if (b[2]) begin
			ord = '{ord[2], ord[3], ord[0], ord[1]};
		end
		ab.winner = '0;
		for (int i = PSC_NM - 1; i >= 0; i--) begin
			if (ab.req[ord[i]]) begin
				ab.winner = '0;
				ab.winner[ord[i]] = 1'b1;
			end
		end
	end

	// each bank flips once per grant it passes, even a lower-input grant
	always_comb begin
		next_tog = tog;
		if (ab.advance) begin
			next_tog[2] = ~tog[2];
			if (ab.winner[PSC_BRIDGE] | ab.winner[PSC_M0]) begin
				next_tog[0] = ~tog[0];
			end
			if (ab.winner[PSC_CPU] | ab.winner[PSC_M1]) begin
				next_tog[1] = ~tog[1];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog <= 3'h0;
		end else begin
			tog <= next_tog;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	winner_one_a: assert property ($onehot0(ab.winner))
		else $error("more than one winner");
	rot_flip_a: assert property (ab.advance && ab.rot[2] |=> tog[2] != $past(tog[2]))
		else $error("bank 2 did not rotate");
endmodule
`default_nettype wire

// file: hdl/psc_top.sv
// pci side control registers, i/o decode, arbiter control and isa path
// assumes all inputs are synchronous to the 50 MHz pci clock
`timescale 1ns/1ns
`default_nettype none
module psc_top #(
	parameter logic [3:0] REVISION = 4'h5 // arbitrary value
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// configuration access
	input wire logic cfg_req_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	output logic cfg_ack_o,
	// i/o decode
	input wire logic io_valid_i,
	input wire logic [15:0] io_addr_i,
	output logic io_page_claim_o,
	output logic io_port92_claim_o,
	output logic io_isa_fwd_o,
	// interrupt acknowledge and subtractive decode
	input wire logic inta_cycle_i,
	input wire logic frame_start_i,
	input wire logic devsel_n_i,
	output logic inta_claim_o,
	output logic sub_fwd_o,
	// buffer modes
	output logic posted_write_buffer_enable_o,
	output logic isa_master_line_buffer_mode_o,
	output logic dma_line_buffer_mode_o,
	// pci arbitration
	input wire logic bridge_bus_request_n_i,
	input wire logic cpu_bus_request_n_i,
	input wire logic [1:0] master_req_n_i,
	input wire logic [psc_pkg::PSC_NM-1:0] retry_i,
	input wire logic bus_idle_i,
	input wire logic lock_start_i,
	input wire logic lock_end_i,
	output logic [psc_pkg::PSC_NM-1:0] gnt_n_o,
	output logic park_drive_o,
	output logic resource_lock_o,
	// isa master path
	input wire logic isa_master_req_i,
	input wire logic mem_bus_gnt_i,
	output logic mem_bus_req_o,
	output logic isa_gnt_o
);
	import psc_pkg::*;

	psc_arb_if ab();

	psc_bank_arb u_core (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.ab(ab.core)
	);

	// register state
	logic [7:0] con;
	logic [7:0] arbc;
	logic [7:0] pri;
	logic [7:0] next_con;
	logic [7:0] next_arbc;
	logic [7:0] next_pri;
	logic [7:0] next_rdata;
	logic wr;

	function automatic logic [6:0] retry_len(input logic [1:0] f);
		case (f)
			2'h1: retry_len = PSC_RT_16;
			2'h2: retry_len = PSC_RT_32;
			2'h3: retry_len = PSC_RT_64;
			default: retry_len = PSC_RT_0;
		endcase
	endfunction

	// writes keep only implemented bits; revision ignores writes
	assign wr = cfg_req_i & cfg_wr_i;
	always_comb begin
		next_con = con;
		next_arbc = arbc;
		next_pri = pri;
		next_rdata = PSC_ZERO;
		if (wr && cfg_addr_i == PSC_CON_OFS) begin
			next_con = cfg_wdata_i & PSC_CON_MSK;
		end
		if (wr && cfg_addr_i == PSC_ARB_OFS) begin
			next_arbc = cfg_wdata_i & PSC_ARB_MSK;
		end
		if (wr && cfg_addr_i == PSC_PRI_OFS) begin
			next_pri = cfg_wdata_i & PSC_PRI_MSK;
		end
		case (cfg_addr_i)
			PSC_REV_OFS: next_rdata = {4'h0, REVISION};
			PSC_CON_OFS: next_rdata = con;
			PSC_ARB_OFS: next_rdata = arbc;
			PSC_PRI_OFS: next_rdata = pri;
			default: next_rdata = PSC_ZERO;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			con <= PSC_CON_RST;
			arbc <= PSC_ARB_RST;
			pri <= PSC_PRI_RST;
			cfg_rdata_o <= PSC_ZERO;
			cfg_ack_o <= 1'b0;
		end else begin
			con <= next_con;
			arbc <= next_arbc;
			pri <= next_pri;
			cfg_rdata_o <= cfg_req_i ? next_rdata : PSC_ZERO;
			cfg_ack_o <= cfg_req_i;
		end
	end

	// mode bits reach the buffers from flops
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			posted_write_buffer_enable_o <= 1'b0;
			isa_master_line_buffer_mode_o <= 1'b0;
			dma_line_buffer_mode_o <= 1'b0;
		end else begin
			posted_write_buffer_enable_o <= next_con[PSC_CON_PWB];
			isa_master_line_buffer_mode_o <= next_con[PSC_CON_ILB];
			dma_line_buffer_mode_o <= next_con[PSC_CON_DLB];
		end
	end

	// i/o decode, one clock after the address
	logic in_page;
	logic in_alias;
	logic is_92;
	logic next_page;
	logic next_p92;
	logic next_fwd;
	logic next_inta;
	always_comb begin
		is_92 = io_addr_i == {PSC_IO_HI, PSC_PORT92};
		in_page = io_addr_i[15:4] == {PSC_IO_HI, PSC_PAGE_NIB};
		in_alias = io_addr_i[15:4] == {PSC_IO_HI, PSC_ALIAS_NIB};
		next_p92 = io_valid_i & is_92;
		next_page = io_valid_i & ~is_92 & (in_page | (in_alias & ~con[PSC_CON_ALIAS]));
		next_fwd = io_valid_i & ~is_92 & in_alias & con[PSC_CON_ALIAS];
		next_inta = inta_cycle_i & con[PSC_CON_INTA];
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_page_claim_o <= 1'b0;
			io_port92_claim_o <= 1'b0;
			io_isa_fwd_o <= 1'b0;
			inta_claim_o <= 1'b0;
		end else begin
			io_page_claim_o <= next_page;
			io_port92_claim_o <= next_p92;
			io_isa_fwd_o <= next_fwd;
			inta_claim_o <= next_inta;
		end
	end

	// subtractive decode: count clocks from frame start, sample devsel once
	logic [2:0] sp_cnt;
	logic [2:0] next_sp_cnt;
	logic [2:0] sp_lim;
	logic next_sub;
	always_comb begin
		case (con[PSC_CON_SP +: 2])
			PSC_SP_SLOW: sp_lim = PSC_SPC_SLOW;
			PSC_SP_TYP: sp_lim = PSC_SPC_TYP;
			PSC_SP_FAST: sp_lim = PSC_SPC_FAST;
			default: sp_lim = PSC_SPC_SLOW; // reserved code acts as slow
		endcase
		next_sp_cnt = sp_cnt;
		if (frame_start_i) begin
			next_sp_cnt = 3'h1;
		end else if (sp_cnt != 3'h0 && sp_cnt != PSC_SPC_MAX) begin
			next_sp_cnt = sp_cnt + 3'h1;
		end
		next_sub = !frame_start_i && sp_cnt == sp_lim && devsel_n_i;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sp_cnt <= 3'h0;
			sub_fwd_o <= 1'b0;
		end else begin
			sp_cnt <= next_sp_cnt;
			sub_fwd_o <= next_sub;
		end
	end

	// retry masking, one timer per requester
	logic [PSC_NM-1:0] mask;
	logic [PSC_NM-1:0] next_mask;
	logic [PSC_RTW-1:0] rcnt [PSC_NM];
	logic [PSC_RTW-1:0] next_rcnt [PSC_NM];
	logic [6:0] rlen;
	assign rlen = retry_len(arbc[PSC_ARB_RETRY +: 2]);
	genvar gi;
	generate
		for (gi = 0; gi < PSC_NM; gi++) begin : g_retry
			always_comb begin
				next_mask[gi] = mask[gi];
				next_rcnt[gi] = rcnt[gi];
				if (mask[gi]) begin
					if (rcnt[gi] == PSC_RT_0) begin
						next_mask[gi] = 1'b0;
					end else begin
						next_rcnt[gi] = rcnt[gi] - 7'h1;
					end
				end else if (retry_i[gi] && rlen != PSC_RT_0) begin
					next_mask[gi] = 1'b1;
					next_rcnt[gi] = rlen - 7'h1;
				end
			end
			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					mask[gi] <= 1'b0;
					rcnt[gi] <= PSC_RT_0;
				end else begin
					mask[gi] <= next_mask[gi];
					rcnt[gi] <= next_rcnt[gi];
				end
			end
		end
	endgenerate

	// request vector; bridge also asks on behalf of the isa path
	psc_isa_t gst;
	psc_isa_t next_gst;
	logic [PSC_NM-1:0] req;
	assign req = {~master_req_n_i[1], ~cpu_bus_request_n_i, ~master_req_n_i[0],
		~bridge_bus_request_n_i | (gst != G_IDLE)};
	assign ab.req = req & ~mask;
	assign ab.sel = pri[2:0];
	assign ab.rot = pri[PSC_PRI_ROT +: 3];

	// arbitration sequencer
	psc_arb_t ast;
	psc_arb_t next_ast;
	logic [PSC_NM-1:0] next_gnt;
	logic next_drive;
	logic next_rlock;
	always_comb begin
		next_ast = ast;
		next_gnt = gnt_n_o;
		next_drive = 1'b0;
		next_rlock = resource_lock_o;
		ab.advance = 1'b0;
		if (lock_end_i) begin
			next_rlock = 1'b0;
		end
		case (ast)
			ARB_IDLE: begin
				if (|ab.req) begin
					next_gnt = ~ab.winner;
					ab.advance = 1'b1;
					next_ast = ARB_OWN;
				end else if (bus_idle_i && arbc[PSC_ARB_PARK]) begin
					next_gnt = PSC_GNT_CPU;
				end else if (bus_idle_i) begin
					next_gnt = PSC_GNT_NONE;
					next_drive = 1'b1;
				end
			end
			ARB_OWN: begin
				if (lock_start_i && arbc[PSC_ARB_LOCK]) begin
					next_ast = ARB_LOCK;
				end else if (lock_start_i) begin
					next_rlock = 1'b1;
				end else if ((req & ~gnt_n_o) == '0) begin
					next_gnt = PSC_GNT_NONE;
					next_ast = ARB_IDLE;
				end
			end
			ARB_LOCK: begin
				if (lock_end_i) begin
					next_ast = ARB_OWN;
				end
			end
			default: next_ast = ARB_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ast <= ARB_IDLE;
			gnt_n_o <= PSC_GNT_NONE;
			park_drive_o <= 1'b0;
			resource_lock_o <= 1'b0;
		end else begin
			ast <= next_ast;
			gnt_n_o <= next_gnt;
			park_drive_o <= next_drive;
			resource_lock_o <= next_rlock;
		end
	end

	// isa master path: order of pci, memory and isa ownership
	logic next_isa;
	logic next_mreq;
	always_comb begin
		next_gst = gst;
		case (gst)
			G_IDLE: begin
				if (isa_master_req_i && arbc[PSC_ARB_GUAR]) begin
					next_gst = G_PCI;
				end else if (isa_master_req_i) begin
					next_gst = G_ISA;
				end
			end
			G_PCI: begin
				if (!gnt_n_o[PSC_BRIDGE]) begin
					next_gst = G_MEM;
				end
			end
			G_MEM: begin
				if (mem_bus_gnt_i) begin
					next_gst = G_ISA;
				end
			end
			G_ISA: begin
				if (!isa_master_req_i) begin
					next_gst = G_IDLE;
				end
			end
			default: next_gst = G_IDLE;
		endcase
		next_isa = next_gst == G_ISA;
		next_mreq = next_gst == G_MEM || (next_gst == G_ISA && gst != G_IDLE && mem_bus_req_o);
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gst <= G_IDLE;
			isa_gnt_o <= 1'b0;
			mem_bus_req_o <= 1'b0;
		end else begin
			gst <= next_gst;
			isa_gnt_o <= next_isa;
			mem_bus_req_o <= next_mreq;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_guar_req;
		gst == G_IDLE && isa_master_req_i && arbc[PSC_ARB_GUAR];
	endsequence
	rev_read_a: assert property (cfg_req_i && cfg_addr_i == PSC_REV_OFS |=>
		cfg_rdata_o == {4'h0, REVISION}) else $error("revision read wrong");
	rsvd_zero_a: assert property (con[7] == 1'b0 && arbc[7:5] == 3'h0 &&
		pri[7] == 1'b0 && pri[3] == 1'b0) else $error("reserved bit set");
	page_alias_a: assert property (io_valid_i && io_addr_i == 16'h0095 &&
		!con[PSC_CON_ALIAS] |=> io_page_claim_o && !io_isa_fwd_o) else $error("alias miss");
	port92_a: assert property (io_valid_i && io_addr_i == 16'h0092 |=>
		io_port92_claim_o && !io_page_claim_o && !io_isa_fwd_o) else $error("port 92 decode");
	inta_gate_a: assert property (inta_cycle_i |=>
		inta_claim_o == $past(con[PSC_CON_INTA])) else $error("inta gating wrong");
	retry_mask_a: assert property (retry_i[PSC_M0] && !mask[PSC_M0] &&
		arbc[PSC_ARB_RETRY +: 2] == 2'h1 |=> mask[PSC_M0] ##15 mask[PSC_M0] ##1 !mask[PSC_M0])
		else $error("retry mask length wrong");
	park_cpu_a: assert property (ast == ARB_IDLE && ab.req == '0 && bus_idle_i &&
		arbc[PSC_ARB_PARK] |=> gnt_n_o == PSC_GNT_CPU) else $error("not parked on cpu");
	idle_drive_a: assert property (ast == ARB_IDLE && ab.req == '0 && bus_idle_i &&
		!arbc[PSC_ARB_PARK] |=> park_drive_o) else $error("idle bus not driven");
	bus_lock_a: assert property (ast == ARB_LOCK |=> $stable(gnt_n_o))
		else $error("grant moved under bus lock");
	guar_order_a: assert property (s_guar_req |=> !isa_gnt_o [*2])
		else $error("isa granted before pci and memory");
	guar_mem_a: assert property ($rose(isa_gnt_o) && $past(arbc[PSC_ARB_GUAR]) |->
		$past(mem_bus_req_o && mem_bus_gnt_i)) else $error("isa granted without memory bus");
	isa_first_a: assert property (gst == G_IDLE && isa_master_req_i &&
		!arbc[PSC_ARB_GUAR] |=> isa_gnt_o) else $error("isa not granted first");
endmodule
`default_nettype wire

// file: shared/psc_arb_if.sv
// carrier between the control top and the bank priority core
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface psc_arb_if;
	logic [3:0] req;
	logic [2:0] sel;
	logic [2:0] rot;
	logic advance;
	logic [3:0] winner;
	modport core(input req, sel, rot, advance, output winner);
	modport ctrl(output req, sel, rot, advance, input winner);
endinterface
`default_nettype wire

// file: shared/psc_pkg.sv
// constants, types and field layout of the pci side control and arbiter
// assumes a single 50 MHz pci clock drives all logic
package psc_pkg;
	// register offsets
	localparam logic [7:0] PSC_REV_OFS = 8'h08;
	localparam logic [7:0] PSC_CON_OFS = 8'h40;
	localparam logic [7:0] PSC_ARB_OFS = 8'h41;
	localparam logic [7:0] PSC_PRI_OFS = 8'h42;
	// reset values and writable masks
	localparam logic [7:0] PSC_CON_RST = 8'h20;
	localparam logic [7:0] PSC_ARB_RST = 8'h00;
	localparam logic [7:0] PSC_PRI_RST = 8'h04;
	localparam logic [7:0] PSC_CON_MSK = 8'h7F;
	localparam logic [7:0] PSC_ARB_MSK = 8'h1F;
	localparam logic [7:0] PSC_PRI_MSK = 8'h77;
	localparam logic [7:0] PSC_ZERO = 8'h00;
	// field positions
	localparam int PSC_CON_ALIAS = 6;
	localparam int PSC_CON_INTA = 5;
	localparam int PSC_CON_SP = 3;
	localparam int PSC_CON_PWB = 2;
	localparam int PSC_CON_ILB = 1;
	localparam int PSC_CON_DLB = 0;
	localparam int PSC_ARB_RETRY = 3;
	localparam int PSC_ARB_PARK = 2;
	localparam int PSC_ARB_LOCK = 1;
	localparam int PSC_ARB_GUAR = 0;
	localparam int PSC_PRI_ROT = 4;
	// masters in request vector order
	localparam int PSC_NM = 4;
	localparam int PSC_BRIDGE = 0;
	localparam int PSC_M0 = 1;
	localparam int PSC_CPU = 2;
	localparam int PSC_M1 = 3;
	localparam logic [3:0] PSC_GNT_NONE = 4'hF;
	localparam logic [3:0] PSC_GNT_CPU = 4'hB;
	// retry mask lengths in clocks
	localparam int PSC_RTW = 7;
	localparam logic [6:0] PSC_RT_16 = 7'h10;
	localparam logic [6:0] PSC_RT_32 = 7'h20;
	localparam logic [6:0] PSC_RT_64 = 7'h40;
	localparam logic [6:0] PSC_RT_0 = 7'h00;
	// devsel sample points, clocks after frame start
	localparam logic [1:0] PSC_SP_SLOW = 2'h0;
	localparam logic [1:0] PSC_SP_TYP = 2'h1;
	localparam logic [1:0] PSC_SP_FAST = 2'h2;
	localparam logic [2:0] PSC_SPC_SLOW = 3'h4;
	localparam logic [2:0] PSC_SPC_TYP = 3'h3;
	localparam logic [2:0] PSC_SPC_FAST = 3'h2;
	localparam logic [2:0] PSC_SPC_MAX = 3'h7;
	// i/o decode
	localparam logic [7:0] PSC_IO_HI = 8'h00;
	localparam logic [3:0] PSC_PAGE_NIB = 4'h8;
	localparam logic [3:0] PSC_ALIAS_NIB = 4'h9;
	localparam logic [7:0] PSC_PORT92 = 8'h92;
	// states
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_OWN = 2'b01,
		ARB_LOCK = 2'b10
	} psc_arb_t;
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_PCI = 2'b01,
		G_MEM = 2'b10,
		G_ISA = 2'b11
	} psc_isa_t;
endpackage

// file: verif/psc_req_model.sv
// behavioural model of the four pci requesters facing the arbiter
// assumes active low grants that are sampled on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module psc_req_model #(
	parameter int HOLD = 2
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// bench control and grants
	input wire logic [3:0] want_i,
	input wire logic [3:0] gnt_n_i,
	// requests, pulled up when released
	output logic [3:0] req_n_o
);
	logic [3:0] done;
	int hold [4];

	// a requester holds its line low until granted, uses the bus, then lets go
	// done keeps it quiet afterwards, so one grant per request is all it takes
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_n_o <= 4'hF;
			done <= 4'h0;
			for (int i = 0; i < 4; i++) hold[i] <= 0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!want_i[i]) begin
					done[i] <= 1'b0;
					req_n_o[i] <= 1'b1;
					hold[i] <= 0;
				end else if (!gnt_n_i[i] && hold[i] == HOLD) begin
					done[i] <= 1'b1;
					req_n_o[i] <= 1'b1;
				end else begin
					req_n_o[i] <= done[i];
					if (!gnt_n_i[i]) hold[i] <= hold[i] + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the pci side control and arbiter top
// assumes the requester model drives the four pci request lines
`timescale 1ns/1ns
`default_nettype none
module tb;
	import psc_pkg::*;
	localparam logic [3:0] REV = 4'h9; // arbitrary stepping value
	logic mclk_i = 0, reset_n_i = 0;
	logic cfg_req_i = 0, cfg_wr_i = 0, cfg_ack_o;
	logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o;
	logic io_valid_i = 0, io_page_claim_o, io_port92_claim_o, io_isa_fwd_o;
	logic [15:0] io_addr_i = 16'h0000;
	logic inta_cycle_i = 0, frame_start_i = 0, devsel_n_i = 1, inta_claim_o, sub_fwd_o;
	logic pwb, ilb, dlb, park_drive_o, resource_lock_o;
	logic bus_idle_i = 0, lock_start_i = 0, lock_end_i = 0;
	logic isa_master_req_i = 0, mem_bus_gnt_i = 0, mem_bus_req_o, isa_gnt_o;
	logic [3:0] retry_i = 4'h0, want = 4'h0, req_n, gnt_n_o;
	int checks = 0, miscompares = 0;

	always #10 mclk_i = ~mclk_i;

	psc_req_model #(.HOLD(4)) i_req (.mclk_i, .reset_n_i, .want_i(want),
		.gnt_n_i(gnt_n_o), .req_n_o(req_n));
	psc_top #(.REVISION(REV)) i_dut (.mclk_i, .reset_n_i, .cfg_req_i, .cfg_wr_i,
		.cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .io_valid_i, .io_addr_i,
		.io_page_claim_o, .io_port92_claim_o, .io_isa_fwd_o, .inta_cycle_i,
		.frame_start_i, .devsel_n_i, .inta_claim_o, .sub_fwd_o,
		.posted_write_buffer_enable_o(pwb), .isa_master_line_buffer_mode_o(ilb),
		.dma_line_buffer_mode_o(dlb), .bridge_bus_request_n_i(req_n[0]),
		.cpu_bus_request_n_i(req_n[2]), .master_req_n_i({req_n[3], req_n[1]}),
		.retry_i, .bus_idle_i, .lock_start_i, .lock_end_i, .gnt_n_o, .park_drive_o,
		.resource_lock_o, .isa_master_req_i, .mem_bus_gnt_i, .mem_bus_req_o, .isa_gnt_o);

	task automatic chk(input string s, input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", s, exp, got);
		end
	endtask

	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// one-cycle strobe, then a bounded wait for the acknowledge
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] r);
		int n;
		n = 0;
		cfg_req_i = 1'b1;
		cfg_wr_i = w;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		tick(1);
		cfg_req_i = 1'b0;
		while (cfg_ack_o !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		r = cfg_rdata_o;
		if (n == 4) begin
			chk("ack wait", 8'h00, 8'h01);
			results();
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		acc(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [7:0] a, e);
		logic [7:0] r;
		acc(1'b0, a, 8'h00, r);
		chk("cfg read", r, e);
	endtask

	task automatic io(input logic [15:0] a, input logic [2:0] e);
		io_valid_i = 1'b1;
		io_addr_i = a;
		tick(1);
		io_valid_i = 1'b0;
		chk("io claim", {5'h0, io_page_claim_o, io_port92_claim_o, io_isa_fwd_o}, {5'h0, e});
	endtask

	// request, note the first winner and its wait, then withdraw everyone
	task automatic round(input logic [3:0] m, output int w, n);
		want = m;
		n = 0;
		w = 9;
		while (gnt_n_o === 4'hF && n < 80) begin
			tick(1);
			n++;
		end
		for (int i = 3; i >= 0; i--) if (gnt_n_o[i] === 1'b0) w = i;
		if (n == 80) begin
			chk("grant wait", 8'h00, 8'h01);
			results();
		end
		want = 4'h0;
		tick(6);
	endtask

	initial begin
		int w, v, n;
		int lens [4] = '{0, 16, 32, 64};
		int sp [4] = '{4, 3, 2, 4};
		tick(10);
		chk("reset grant", {4'h0, gnt_n_o}, 8'h0F);
		reset_n_i = 1'b1;
		rdc(PSC_REV_OFS, {4'h0, REV});
		wr(PSC_REV_OFS, 8'hFF);
		rdc(PSC_REV_OFS, {4'h0, REV});
		rdc(PSC_CON_OFS, 8'h20);
		rdc(PSC_ARB_OFS, 8'h00);
		rdc(PSC_PRI_OFS, 8'h04);
		rdc(8'h50, 8'h00);
		wr(PSC_CON_OFS, 8'hFF);
		rdc(PSC_CON_OFS, 8'h7F);
		wr(PSC_ARB_OFS, 8'hFF);
		rdc(PSC_ARB_OFS, 8'h1F);
		wr(PSC_PRI_OFS, 8'hFF);
		rdc(PSC_PRI_OFS, 8'h77);
		// buffer mode copies follow the control register
		wr(PSC_CON_OFS, 8'h07);
		chk("buffer modes", {5'h0, pwb, ilb, dlb}, 8'h07);
		wr(PSC_CON_OFS, 8'h02);
		chk("buffer modes", {5'h0, pwb, ilb, dlb}, 8'h02);
		// page alias decode, both settings, port 92h kept apart
		wr(PSC_CON_OFS, 8'h20);
		io(16'h0085, 3'b100);
		io(16'h0095, 3'b100);
		io(16'h0092, 3'b010);
		io(16'h0185, 3'b000);
		wr(PSC_CON_OFS, 8'h60);
		io(16'h0095, 3'b001);
		io(16'h008F, 3'b100);
		io(16'h0092, 3'b010);
		// interrupt acknowledge claimed only while enabled
		for (int k = 1; k >= 0; k--) begin
			wr(PSC_CON_OFS, 8'(k << 5));
			inta_cycle_i = 1'b1;
			tick(1);
			inta_cycle_i = 1'b0;
			chk("inta claim", {7'h0, inta_claim_o}, 8'(k));
		end
		// every sample point code, then a claimed cycle that must stay
		for (int k = 0; k < 5; k++) begin
			wr(PSC_CON_OFS, 8'((k & 3) << 3));
			devsel_n_i = (k < 4);
			frame_start_i = 1'b1;
			tick(1);
			frame_start_i = 1'b0;
			n = 0;
			while (sub_fwd_o !== 1'b1 && n < 10) begin
				tick(1);
				n++;
			end
			chk("sample point", 8'(n), 8'(k < 4 ? sp[k] : 10));
		end
		devsel_n_i = 1'b1;
		// fixed orderings, all rotate bits clear
		for (int s = 0; s < 8; s++) begin
			wr(PSC_PRI_OFS, 8'(s));
			round(4'hF, w, n);
			chk("fixed winner", 8'(w), 8'(s[2] ? (s[1] ? 3 : 2) : (s[0] ? 1 : 0)));
		end
		// bank 2 rotating, its select bit ignored
		for (int k = 0; k < 2; k++) begin
			wr(PSC_PRI_OFS, k ? 8'h44 : 8'h40);
			round(4'hF, w, n);
			round(4'hF, v, n);
			chk("rotation", 8'(v[1] ^ w[1]), 8'h01);
			round(4'h8, w, n);
			chk("lower input", 8'(w), 8'h03);
		end
		// retry mask lengths for every timer code
		wr(PSC_PRI_OFS, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(PSC_ARB_OFS, 8'(k << 3));
			retry_i = 4'h2;
			tick(1);
			retry_i = 4'h0;
			round(4'h2, w, n);
			chk("mask length", 8'(n >= lens[k] && n <= lens[k] + 3), 8'h01);
		end
		// resource lock then bus lock, master 0 owning the bus
		for (int k = 0; k < 2; k++) begin
			wr(PSC_ARB_OFS, 8'(k << 1));
			want = 4'h2;
			tick(3);
			lock_start_i = 1'b1;
			tick(1);
			lock_start_i = 1'b0;
			want = 4'h0;
			tick(8);
			chk("locked", {3'h0, resource_lock_o, gnt_n_o}, k ? 8'h0D : 8'h1F);
			lock_end_i = 1'b1;
			tick(1);
			lock_end_i = 1'b0;
			tick(4);
			chk("unlocked", {3'h0, resource_lock_o, gnt_n_o}, 8'h0F);
		end
		// isa master with and without guaranteed access
		wr(PSC_ARB_OFS, 8'h01);
		isa_master_req_i = 1'b1;
		tick(4);
		chk("isa early", {7'h0, isa_gnt_o}, 8'h00);
		n = 0;
		while (mem_bus_req_o !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk("mem request", {7'h0, mem_bus_req_o}, 8'h01);
		mem_bus_gnt_i = 1'b1;
		tick(2);
		chk("isa granted", {7'h0, isa_gnt_o}, 8'h01);
		isa_master_req_i = 1'b0;
		mem_bus_gnt_i = 1'b0;
		tick(3);
		wr(PSC_ARB_OFS, 8'h00);
		isa_master_req_i = 1'b1;
		tick(1);
		chk("isa first", {7'h0, isa_gnt_o}, 8'h01);
		tick(3);
		chk("bridge asks", {7'h0, gnt_n_o[0]}, 8'h00);
		isa_master_req_i = 1'b0;
		tick(4);
		// idle bus: drive it ourselves, then park on the cpu
		bus_idle_i = 1'b1;
		tick(3);
		chk("idle drive", {3'h0, park_drive_o, gnt_n_o}, 8'h1F);
		bus_idle_i = 1'b0;
		tick(3);
		chk("busy no drive", {7'h0, park_drive_o}, 8'h00);
		wr(PSC_ARB_OFS, 8'h04);
		bus_idle_i = 1'b1;
		tick(3);
		chk("parked", {3'h0, park_drive_o, gnt_n_o}, 8'h0B);
		results();
	end
endmodule
`default_nettype wire
